/* File: verilog/srwd_top.sv */
// Supply reset and watchdog supervisor with APB registers
// Notes on behaviour
// - Steady watchdog input past timeout asserts reset
// - Reset or kick edge clears watchdog timer
// - After reset, 54 s allowed for first kick
// - Floating watchdog input disables the watchdog
// - Manual reset low drives reset low
// - Reset held full timeout after manual release
// - Any low supply or manual reset asserts reset
// - Release only after timeout from all-good
// - Timeout select high: internal, else capacitor scaled
// - Tolerance select picks 5% or 10% thresholds
// - Each channel output follows its own supply
// - Margin low forces reset and channel outputs high
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
`timescale 1ns/10ps

module srwd_top
	import srwd_pkg::*;
#(
	parameter logic [31:0] RST_CYCLES     = RST_TIMEOUT_CYC,
	parameter logic [31:0] WD_CYCLES      = WD_TIMEOUT_CYC,
	parameter logic [31:0] STARTUP_CYCLES = WD_STARTUP_CYC
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            clk_en,
	input  wire logic [7:0]      paddr,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [NCH-1:0]  monitored_supply,
	input  wire logic            manual_reset_n,
	input  wire logic            margin_n,
	input  wire logic            watchdog_kick_in,
	input  wire logic            watchdog_open,
	input  wire logic            timeout_select,
	input  wire logic            tolerance_select,
	output logic                 reset_n,
	output logic      [NCH-1:0]  channel_good_n,
	output logic                 threshold_set,
	output logic                 irq
);

	typedef struct packed {
		srwd_wd_type      wd_st;
		logic [31:0]      wd_cnt;
		logic             wd_last;
		logic             wd_exp;
		logic             rst_on;
		logic [31:0]      rst_cnt;
		logic [15:0]      cap;
		logic [3:0]       istat;
		logic [3:0]       imask;
		logic [NCH-1:0]   sup_last;
		logic             manual_last;
		logic             reset_n;
		logic [NCH-1:0]   good_n;
		logic             toler;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             irq;
	} srwd_state_type;

	srwd_state_type       st_q;
	srwd_state_type       st_d;
	logic [SYNC_W-1:0]    pins_s;
	logic [NCH-1:0]       sup_s;
	logic                 manual_s;
	logic                 margin_s;
	logic                 kick_s;
	logic                 open_s;
	logic                 tsel_s;
	logic                 toler_s;
	logic                 kick_edge;
	logic                 rst_cause;
	logic [31:0]          rst_lim;
	logic [47:0]          cap_cyc;
	logic                 wr_en;
	logic                 rd_setup;
	logic [3:0]           ev;

	// ==================================================================
	// Helpers
	// ==================================================================
	function automatic logic reg_hit(input logic [7:0] addr,
		input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// ==================================================================
	// Pin synchronisers
	// ==================================================================
	// all pins re-timed
	srwd_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.d       ({tolerance_select, timeout_select, watchdog_open,
			watchdog_kick_in, margin_n, manual_reset_n,
			monitored_supply}),
		.q       (pins_s)
	);

	assign sup_s    = pins_s[SY_SUP +: NCH];
	assign manual_s = pins_s[SY_MANUAL];
	assign margin_s = pins_s[SY_MARGIN];
	assign kick_s   = pins_s[SY_KICK];
	assign open_s   = pins_s[SY_OPEN];
	assign tsel_s   = pins_s[SY_TSEL];
	assign toler_s  = pins_s[SY_TOLER];

	// edges from the synchronised samples only
	assign kick_edge = kick_s ^ st_q.wd_last;

	assign rst_cause = ~(&sup_s) | ~manual_s | st_q.wd_exp;

	// capacitor timeout saturates rather than wraps
	assign cap_cyc = 48'(st_q.cap) * 48'(CAP_CYC_PER_NF);
	always_comb begin
		if (tsel_s) begin
			rst_lim = RST_CYCLES;
		end else if (|cap_cyc[47:32]) begin
			rst_lim = 32'hffff_ffff;
		end else begin
			rst_lim = cap_cyc[31:0];
		end
	end

	assign wr_en    = psel & penable & st_q.pready & pwrite;
	assign rd_setup = psel & ~penable;

	// ==================================================================
	// Next state
	// ==================================================================
	always_comb begin
		st_d          = st_q;
		st_d.wd_last     = kick_s;
		st_d.sup_last    = sup_s;
		st_d.manual_last = manual_s;
		st_d.wd_exp   = 1'b0;

		// Reset timeout counter
		if (rst_cause) begin
			st_d.rst_on  = 1'b1;
			st_d.rst_cnt = 32'h0;
		end else if (st_q.rst_on) begin
			// hold the full timeout from all-good
			if (st_q.rst_cnt + 32'h1 >= rst_lim) begin
				st_d.rst_on  = 1'b0;
				st_d.rst_cnt = 32'h0;
			end else begin
				st_d.rst_cnt = st_q.rst_cnt + 32'h1;
			end
		end

		// Watchdog
		if (open_s) begin
			st_d.wd_st  = WD_OFF;
			st_d.wd_cnt = 32'h0;
		end else if (st_q.rst_on) begin
			st_d.wd_st  = WD_START;
			st_d.wd_cnt = 32'h0;
		end else begin
			unique case (st_q.wd_st)
				WD_OFF: begin
					st_d.wd_st  = WD_START;
					st_d.wd_cnt = 32'h0;
				end
				WD_START: begin
					if (kick_edge) begin
						st_d.wd_st  = WD_RUN;
						st_d.wd_cnt = 32'h0;
					// long window for the first kick
					end else if (st_q.wd_cnt + 32'h1 >= STARTUP_CYCLES) begin
						st_d.wd_exp = 1'b1;
						st_d.wd_cnt = 32'h0;
					end else begin
						st_d.wd_cnt = st_q.wd_cnt + 32'h1;
					end
				end
				WD_RUN: begin
					if (kick_edge) begin
						st_d.wd_cnt = 32'h0;
					// steady input runs out the timer
					end else if (st_q.wd_cnt + 32'h1 >= WD_CYCLES) begin
						st_d.wd_exp = 1'b1;
						st_d.wd_cnt = 32'h0;
					end else begin
						st_d.wd_cnt = st_q.wd_cnt + 32'h1;
					end
				end
			endcase
		end

		// Events
		ev              = 4'h0;
		ev[IRQ_SUPPLY]  = |(st_q.sup_last & ~sup_s);
		ev[IRQ_MANUAL]  = st_q.manual_last & ~manual_s;
		ev[IRQ_WDOG]    = st_q.wd_exp;
		ev[IRQ_RELEASE] = st_q.rst_on & ~st_d.rst_on;

		// Register writes; a new event beats a clear
		if (wr_en && reg_hit(paddr, REG_TIME_CAP)) begin
			st_d.cap = pwdata[15:0];
		end
		if (wr_en && reg_hit(paddr, REG_IRQ_MASK)) begin
			st_d.imask = pwdata[3:0];
		end
		if (wr_en && reg_hit(paddr, REG_IRQ_STAT)) begin
			st_d.istat = st_q.istat & ~pwdata[3:0];
		end
		st_d.istat = st_d.istat | ev;
		st_d.irq   = |(st_d.istat & st_d.imask);

		// Read answer prepared in setup, shown in access
		st_d.pready  = rd_setup;
		st_d.pslverr = 1'b0;
		st_d.prdata  = 32'h0;
		if (rd_setup) begin
			if (reg_hit(paddr, REG_TIME_CAP)) begin
				st_d.prdata[15:0] = st_q.cap;
			end else if (reg_hit(paddr, REG_STATE)) begin
				st_d.prdata[ST_RESET_N]        = st_q.reset_n;
				st_d.prdata[ST_WD_RUN]         = st_q.wd_st == WD_RUN;
				st_d.prdata[ST_WD_OPEN]        = st_q.wd_st == WD_OFF;
				st_d.prdata[ST_TSEL]           = tsel_s;
				st_d.prdata[ST_TOLER]          = st_q.toler;
				st_d.prdata[ST_SUPPLY +: NCH]  = sup_s;
			end else if (reg_hit(paddr, REG_IRQ_STAT)) begin
				st_d.prdata[3:0] = st_q.istat;
			end else if (reg_hit(paddr, REG_IRQ_MASK)) begin
				st_d.prdata[3:0] = st_q.imask;
			end else begin
				st_d.pslverr = 1'b1;
			end
		end

		st_d.toler = toler_s;

		if (!margin_s) begin
			st_d.reset_n = 1'b1;
			st_d.good_n  = {NCH{1'b1}};
		end else begin
			st_d.reset_n = ~st_d.rst_on;
			// each channel on its own supply
			st_d.good_n  = sup_s;
		end
	end

	// ==================================================================
	// State register
	// ==================================================================
	// Power-up starts in reset so the timeout runs once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q          <= '0;
			st_q.wd_st    <= WD_OFF;
			st_q.wd_last     <= SYNC_RST[SY_KICK];
			st_q.manual_last <= 1'b1;
			st_q.rst_on      <= 1'b1;
			st_q.cap         <= TIME_CAP_RST;
			st_q.imask    <= IRQ_MASK_RST;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign prdata         = st_q.prdata;
	assign pready         = st_q.pready;
	assign pslverr        = st_q.pslverr;
	assign reset_n        = st_q.reset_n;
	assign channel_good_n = st_q.good_n;
	assign threshold_set  = st_q.toler;
	assign irq            = st_q.irq;

	// ==================================================================
	// Checks
	// ==================================================================
	chk_wd_expire_rst: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_q.wd_exp |=> st_q.rst_on)
		else $error("watchdog expiry did not assert reset");

	chk_wd_run_bound: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_q.wd_st == WD_RUN |-> st_q.wd_cnt < WD_CYCLES)
		else $error("watchdog count passed its timeout");

	chk_wd_kick_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && kick_edge && !open_s && !st_q.rst_on
		&& st_q.wd_st != WD_OFF
		|=> st_q.wd_cnt == 32'h0 && st_q.wd_st == WD_RUN && !st_q.wd_exp)
		else $error("kick edge did not clear watchdog");

	chk_wd_rst_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_q.rst_on && !open_s
		|=> st_q.wd_st == WD_START && st_q.wd_cnt == 32'h0)
		else $error("watchdog not cleared during reset");

	chk_startup_window: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_q.wd_st == WD_START && !st_q.rst_on && !open_s
		&& !kick_edge && st_q.wd_cnt + 32'h1 < STARTUP_CYCLES
		|=> !st_q.wd_exp && st_q.wd_cnt == $past(st_q.wd_cnt) + 32'h1)
		else $error("startup window cut short");

	chk_wd_open_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && open_s |=> st_q.wd_st == WD_OFF && !st_q.wd_exp)
		else $error("floating input left watchdog running");

	chk_manual_assert: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && !manual_s && margin_s |=> !reset_n)
		else $error("manual reset did not drive reset low");

	chk_supply_assert: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && !(&sup_s) && margin_s |=> !reset_n && st_q.rst_cnt == 0)
		else $error("low supply did not assert reset");

	chk_hold_timeout: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_q.rst_on && !rst_cause
		&& st_q.rst_cnt + 32'h1 < rst_lim
		|=> st_q.rst_on && st_q.rst_cnt == $past(st_q.rst_cnt) + 32'h1)
		else $error("reset released before its timeout");

	chk_release_at_lim: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_q.rst_on && !rst_cause
		&& st_q.rst_cnt + 32'h1 >= rst_lim
		|=> !st_q.rst_on && reset_n)
		else $error("reset not released at timeout");

	chk_timeout_src: assert property (
		@(posedge pclk) disable iff (!presetn)
		tsel_s |-> rst_lim == RST_CYCLES)
		else $error("internal timeout not selected");

	chk_strap_follow: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en |=> threshold_set == $past(toler_s))
		else $error("threshold set does not follow strap");

	chk_chan_follow: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && margin_s |=> channel_good_n == $past(sup_s))
		else $error("channel output does not follow supply");

	chk_margin_force: assert property (
		@(posedge pclk) disable iff (!presetn)
		clk_en && !margin_s |=> reset_n && &channel_good_n)
		else $error("margin did not force outputs high");

endmodule : srwd_top

`default_nettype wire

/* File: verilog/srwd_pkg.sv */
// Constants and types shared by the supply reset watchdog block
`default_nettype none

package srwd_pkg;

	// ==================================================================
	// Timebase, times in their own units
	// ==================================================================
	// 40 MHz
	localparam logic [63:0] CLK_HZ         = 64'h0000_0000_0262_5a00;
	// 140 ms least reset timeout
	localparam logic [63:0] RST_TIMEOUT_MS = 64'h0000_0000_0000_008c;
	// 1600 ms watchdog timeout
	localparam logic [63:0] WD_TIMEOUT_MS  = 64'h0000_0000_0000_0640;
	// 54 s startup period
	localparam logic [63:0] WD_STARTUP_S   = 64'h0000_0000_0000_0036;
	// 2.06 megohm, in hundredths
	localparam logic [63:0] CAP_MOHM_X100  = 64'h0000_0000_0000_00ce;
	localparam logic [63:0] MS_PER_S       = 64'h0000_0000_0000_03e8;
	localparam logic [63:0] OHM_PER_MOHM_X100 = 64'h0000_0000_0000_2710;
	localparam logic [63:0] NF_PER_F       = 64'h0000_0000_3b9a_ca00;

	// ==================================================================
	// Derived cycle counts
	// ==================================================================
	// Least time, so round up
	localparam logic [31:0] RST_TIMEOUT_CYC = 32'((RST_TIMEOUT_MS * CLK_HZ
		+ MS_PER_S - 64'h1) / MS_PER_S);
	localparam logic [31:0] WD_TIMEOUT_CYC  = 32'((WD_TIMEOUT_MS * CLK_HZ)
		/ MS_PER_S);
	localparam logic [31:0] WD_STARTUP_CYC  = 32'(WD_STARTUP_S * CLK_HZ);
	// Cycles of reset timeout per nF of timing capacitor
	localparam logic [31:0] CAP_CYC_PER_NF  = 32'((CAP_MOHM_X100
		* OHM_PER_MOHM_X100 * CLK_HZ) / NF_PER_F);

	// ==================================================================
	// Channels and input synchroniser layout
	// ==================================================================
	localparam int          NCH       = 4;
	localparam int          SYNC_W    = 10;
	localparam int          SY_SUP    = 0;
	localparam int          SY_MANUAL = 4;
	localparam int          SY_MARGIN = 5;
	localparam int          SY_KICK   = 6;
	localparam int          SY_OPEN   = 7;
	localparam int          SY_TSEL   = 8;
	localparam int          SY_TOLER  = 9;
	localparam logic [9:0]  SYNC_RST  = 10'h1b0;

	// ==================================================================
	// Register map
	// ==================================================================
	localparam logic [7:0]  REG_TIME_CAP = 8'h00;
	localparam logic [7:0]  REG_STATE    = 8'h04;
	localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
	localparam logic [7:0]  REG_IRQ_MASK = 8'h0c;
	localparam logic [15:0] TIME_CAP_RST = 16'h0002;
	localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
	localparam int          IRQ_SUPPLY   = 0;
	localparam int          IRQ_MANUAL   = 1;
	localparam int          IRQ_WDOG     = 2;
	localparam int          IRQ_RELEASE  = 3;
	localparam int          ST_RESET_N   = 0;
	localparam int          ST_WD_RUN    = 1;
	localparam int          ST_WD_OPEN   = 2;
	localparam int          ST_TSEL      = 3;
	localparam int          ST_TOLER     = 4;
	localparam int          ST_SUPPLY    = 8;

	typedef enum logic [1:0] {WD_OFF, WD_START, WD_RUN} srwd_wd_type;

endpackage : srwd_pkg

`default_nettype wire

/* File: verilog/srwd_sync.sv */
// Two-stage synchroniser bank for asynchronous pins
`default_nettype none
`timescale 1ns/10ps

module srwd_sync #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          clk_en,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} srwd_sync_state_type;

	srwd_sync_state_type st_q;
	srwd_sync_state_type st_d;

	// ==================================================================
	// Stages
	// ==================================================================
	// First stage feeds only the second
	always_comb begin
		st_d    = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= {RST_VAL, RST_VAL};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;

endmodule : srwd_sync

`default_nettype wire

/* File: verif/srwd_cpu_model.sv */
// Processor model that toggles the watchdog kick line
`default_nettype none
`timescale 1ns/10ps

module srwd_cpu_model #(
	parameter int HALF = 20
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	output logic      kick
);
	int cnt_q;

	// kick well inside timeout
	// Stopping run leaves the line steady, as a hung program would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			kick  <= 1'b0;
		end else if (run) begin
			if (cnt_q == HALF - 1) begin
				cnt_q <= 0;
				kick  <= ~kick;
			end else begin
				cnt_q <= cnt_q + 1;
			end
		end
	end
endmodule : srwd_cpu_model

`default_nettype wire

/* File: verif/srwd_top_test.sv */
// Self-checking testbench for the supply reset watchdog block
`default_nettype none
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); \
	n_fail++; end end

module srwd_top_test;
	import srwd_pkg::*;
	localparam int RC = 20;
	localparam int WC = 50;
	localparam int SC = 100;
	localparam logic [NCH-1:0] LOW2 = NCH'(4'h4);

	logic            pclk, presetn, psel, penable, pwrite;
	logic [7:0]      paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic            pready, pslverr, er;
	logic [NCH-1:0]  monitored_supply, channel_good_n;
	logic            manual_reset_n, margin_n, watchdog_kick_in;
	logic            watchdog_open, timeout_select, tolerance_select;
	logic            reset_n, threshold_set, irq, cpu_run, clk_en;
	int              n_fail, cmp_count, n;

	srwd_top #(.RST_CYCLES(RC), .WD_CYCLES(WC), .STARTUP_CYCLES(SC))
	srwd_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .monitored_supply(monitored_supply),
		.manual_reset_n(manual_reset_n), .margin_n(margin_n),
		.watchdog_kick_in(watchdog_kick_in),
		.watchdog_open(watchdog_open), .timeout_select(timeout_select),
		.tolerance_select(tolerance_select), .reset_n(reset_n),
		.channel_good_n(channel_good_n), .threshold_set(threshold_set),
		.irq(irq));

	srwd_cpu_model #(.HALF(20)) srwd_cpu_model_i (.pclk(pclk),
		.presetn(presetn), .run(cpu_run), .kick(watchdog_kick_in));

	// ==============================================================
	// Shared tasks
	// ==============================================================
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		`CHK("pready", 1'b1, pready)
	endtask : apb

	// Cycles until reset_n shows lvl, capped at max
	task automatic wait_lvl(input logic lvl, input int max);
		n = 0;
		while (reset_n !== lvl && n < max) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_lvl

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// ==============================================================
	// Scenarios
	// ==============================================================
	task automatic t_init;
		`CHK("reset_n in reset", 1'b0, reset_n)
		wait_lvl(1'b1, RC + 20);
		`CHK("release", 1'b1, reset_n)
		`CHK("release late", 1'b1, n >= RC)
		apb(1'b0, 8'h00, 32'h0);
		`CHK("cap reset", 32'h0000_0002, rd)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK("mask reset", 32'h0000_0000, rd)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0000_0000, rd)
		$display("test init done");
	endtask : t_init

	task automatic t_manual;
		apb(1'b1, 8'h08, 32'h0000_000f);
		apb(1'b1, 8'h0c, 32'h0000_0002);
		@(posedge pclk);
		manual_reset_n <= 1'b0;
		wait_lvl(1'b0, 8);
		`CHK("manual assert", 1'b0, reset_n)
		`CHK("manual delay", 1'b1, n <= 4)
		repeat (3) @(posedge pclk);
		`CHK("irq manual", 1'b1, irq)
		manual_reset_n <= 1'b1;
		wait_lvl(1'b1, RC + 12);
		`CHK("manual release", 1'b1, reset_n)
		`CHK("manual hold", 1'b1, n >= RC)
		apb(1'b1, 8'h08, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b1, 8'h0c, 32'h0000_0000);
		$display("test manual done");
	endtask : t_manual

	task automatic t_supply;
		monitored_supply <= ~LOW2;
		repeat (5) @(posedge pclk);
		`CHK("channel low", ~LOW2, channel_good_n)
		`CHK("supply reset", 1'b0, reset_n)
		margin_n <= 1'b0;
		repeat (5) @(posedge pclk);
		`CHK("margin chan", {NCH{1'b1}}, channel_good_n)
		`CHK("margin reset", 1'b1, reset_n)
		margin_n <= 1'b1;
		repeat (5) @(posedge pclk);
		`CHK("unmargined", 1'b0, reset_n)
		apb(1'b0, 8'h08, 32'h0);
		`CHK("supply event", 1'b1, rd[0])
		monitored_supply <= '1;
		wait_lvl(1'b1, RC + 12);
		`CHK("supply release", 1'b1, reset_n)
		`CHK("supply hold", 1'b1, n >= RC)
		`CHK("channel back", {NCH{1'b1}}, channel_good_n)
		$display("test supply done");
	endtask : t_supply

	task automatic t_select;
		tolerance_select <= 1'b1;
		repeat (5) @(posedge pclk);
		`CHK("tol high", 1'b1, threshold_set)
		apb(1'b0, 8'h04, 32'h0);
		`CHK("state sel", 2'b11, rd[4:3])
		tolerance_select <= 1'b0;
		repeat (5) @(posedge pclk);
		`CHK("tol low", 1'b0, threshold_set)
		// Enable low freezes synchronisers and outputs alike
		clk_en           <= 1'b0;
		tolerance_select <= 1'b1;
		repeat (5) @(posedge pclk);
		`CHK("frozen", 1'b0, threshold_set)
		clk_en <= 1'b1;
		repeat (5) @(posedge pclk);
		`CHK("thawed", 1'b1, threshold_set)
		// One nF asks for far more cycles than the internal hold
		timeout_select <= 1'b0;
		apb(1'b1, 8'h00, 32'h0000_0001);
		apb(1'b0, 8'h04, 32'h0);
		`CHK("state cap sel", 1'b0, rd[3])
		manual_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		manual_reset_n <= 1'b1;
		wait_lvl(1'b1, 200);
		`CHK("cap hold", 1'b0, reset_n)
		// Zero capacitance leaves no hold at all
		apb(1'b1, 8'h00, 32'h0);
		wait_lvl(1'b1, 6);
		`CHK("cap zero", 1'b1, reset_n)
		timeout_select <= 1'b1;
		$display("test select done");
	endtask : t_select

	task automatic t_wdog;
		watchdog_open <= 1'b0;
		wait_lvl(1'b0, 200);
		`CHK("kicked alive", 1'b1, reset_n)
		cpu_run <= 1'b0;
		wait_lvl(1'b0, WC + 60);
		`CHK("expiry", 1'b0, reset_n)
		`CHK("expiry time", 1'b1, n >= WC - 22 && n <= WC + 10)
		wait_lvl(1'b1, RC + 20);
		apb(1'b0, 8'h08, 32'h0);
		`CHK("wdog event", 1'b1, rd[2])
		wait_lvl(1'b0, SC + WC + 20);
		`CHK("startup end", 1'b0, reset_n)
		`CHK("startup span", 1'b1, n >= SC - 10)
		cpu_run <= 1'b1;
		wait_lvl(1'b1, RC + 20);
		watchdog_open <= 1'b1;
		cpu_run       <= 1'b0;
		wait_lvl(1'b0, 300);
		`CHK("open no reset", 1'b1, reset_n)
		cpu_run <= 1'b1;
		$display("test wdog done");
	endtask : t_wdog

	// ==============================================================
	// Clock, reset, sequence, watchdog
	// ==============================================================
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		#(25 * 20000);
		n_fail++;
		give_verdict();
	end

	initial begin
		n_fail = 0;
		cmp_count = 0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		monitored_supply = '1;
		manual_reset_n = 1'b1;
		margin_n = 1'b1;
		watchdog_open = 1'b1;
		timeout_select = 1'b1;
		tolerance_select = 1'b0;
		cpu_run = 1'b1;
		clk_en = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_init();
		t_manual();
		t_supply();
		t_select();
		t_wdog();
		give_verdict();
	end
endmodule : srwd_top_test

`default_nettype wire
